/* File: core/flash_host_pkg.sv */
// Shared constants and types for the flash bus host controller
package flash_host_pkg;
    // ==========================================
    // Clock and bus geometry
    localparam int CLK_PERIOD_NS = 5;        // 200 MHz system clock
    localparam int ADDR_W = 21;              // Byte address A0..A20
    localparam int DATA_W = 16;              // Data lines DQ0..DQ15
    localparam int BLOCK_LSB = 16;           // Block number starts at byte address bit 16
    localparam int BLOCK_W = 5;              // 32 uniform 64K-byte blocks
    localparam int SYNC_STAGES = 2;          // Pin input synchroniser depth

    // ==========================================
    // Bus timing, in ns as chosen, and derived cycle counts (least times round up)
    localparam int T_ADDR_SETUP_NS = 10;     // Address/data stable before strobe
    localparam int T_WE_PULSE_NS = 50;       // Write-enable low width
    localparam int T_WR_HOLD_NS = 10;        // Address/data held after write-enable rise
    localparam int T_READ_ACCESS_NS = 100;   // Select/output-enable low to data valid
    localparam int T_RP_LOW_NS = 100;        // Reset/power-down low width
    localparam int T_WAKE_NS = 1000;         // Wake-up after reset/power-down release
    localparam int T_RECOVER_NS = 20;        // Idle gap between bus cycles

    localparam int ADDR_SETUP_CYC = (T_ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WE_PULSE_CYC = (T_WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WR_HOLD_CYC = (T_WR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READ_CYC = (T_READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS
                              + SYNC_STAGES;
    localparam int RP_LOW_CYC = (T_RP_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_CYC = (T_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECOVER_CYC = (T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int TMR_W = 8;                // Phase timer width

    // ==========================================
    // User requests
    typedef enum logic [2:0] {
        OP_READ_ARRAY,
        OP_READ_IDENT,
        OP_READ_QUERY,
        OP_READ_STATUS,
        OP_WRITE,
        OP_DEV_RESET
    } op_e;

    // Read source the device is believed to present
    typedef enum logic [2:0] {
        SRC_UNKNOWN,
        SRC_ARRAY,
        SRC_IDENT,
        SRC_QUERY,
        SRC_STATUS
    } src_e;
endpackage

/* File: core/phase_timer_if.sv */
// Carrier between the host sequencer and its phase timer
`timescale 1ns/10ps
interface phase_timer_if;
    logic start;                              // One-cycle start pulse
    logic [flash_host_pkg::TMR_W-1:0] load;   // Phase length in cycles, at least 1
    logic done;                               // One-cycle pulse when the phase ends
    modport ctrl (output start, output load, input done);
    modport timer (input start, input load, output done);
endinterface

/* File: core/phase_timer.sv */
// Down-counter that times one bus phase
`timescale 1ns/10ps
module phase_timer (
    input wire logic clk,
    input wire logic rst,
    phase_timer_if.timer t
);
    // ==========================================
    // Counter
    logic [flash_host_pkg::TMR_W-1:0] count; // Cycles left in the phase
    logic running;                            // Phase in progress

    // Load on start, pulse done after load cycles
    always_ff @(posedge clk) begin
        if (rst) begin
            count <= '0;
            running <= 1'b0;
            t.done <= 1'b0;
        end else begin
            t.done <= 1'b0;
            if (t.start) begin
                count <= t.load;
                running <= 1'b1;
            end else if (running) begin
                // Last cycle of the phase
                if (count <= flash_host_pkg::TMR_W'(1)) begin
                    running <= 1'b0;
                    t.done <= 1'b1;
                end
                count <= count - flash_host_pkg::TMR_W'(1);
            end
        end
    end
endmodule

/* File: core/flash_host_ctrl.sv */
// Host-side controller driving a parallel block-erasable flash device
`timescale 1ns/10ps
module flash_host_ctrl #(
    parameter logic [7:0] CMD_READ_ARRAY = 8'hff,   // Read-mode command codes
    parameter logic [7:0] CMD_READ_IDENT = 8'h90,
    parameter logic [7:0] CMD_READ_QUERY = 8'h98,
    parameter logic [7:0] CMD_READ_STATUS = 8'h70,
    parameter int WAKE_CYCLES = flash_host_pkg::WAKE_CYC  // Wake-up wait after reset pulse
) (
    input wire logic clk,
    input wire logic rst,
    // User request port
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [2:0] req_op,
    input wire logic [flash_host_pkg::ADDR_W-1:0] req_addr,
    input wire logic [flash_host_pkg::DATA_W-1:0] req_wdata,
    output logic rsp_valid,
    output logic [flash_host_pkg::DATA_W-1:0] rsp_data,
    output logic [flash_host_pkg::BLOCK_W-1:0] rsp_block,
    output logic dev_busy,
    // Flash pins
    output logic [flash_host_pkg::ADDR_W-1:0] flash_addr,
    input wire logic [flash_host_pkg::DATA_W-1:0] flash_dq_in,
    output logic [flash_host_pkg::DATA_W-1:0] flash_dq_out,
    output logic flash_dq_oe,
    output logic chip_select_a_n,
    output logic chip_select_b_n,
    output logic flash_oe_n,
    output logic flash_we_n,
    output logic reset_powerdown_n,
    input wire logic ready_busy_out
);
    // ==========================================
    // Elaboration checks
    // Wake wait must fit the phase timer and be at least one cycle
    if (WAKE_CYCLES < 1 || WAKE_CYCLES >= (1 << flash_host_pkg::TMR_W)) begin : g_wake_check
        $error("WAKE_CYCLES out of timer range");
    end

    // ==========================================
    // Pin input synchronisers
    logic [flash_host_pkg::DATA_W-1:0] dq_meta;   // First stage, read only by dq_sync
    logic [flash_host_pkg::DATA_W-1:0] dq_sync;   // Stable read data
    logic rb_meta;                                // First stage, read only by rb_sync
    logic rb_sync;                                // Stable ready/busy level

    // Two flops before any logic looks at the pins
    always_ff @(posedge clk) begin
        if (rst) begin
            dq_meta <= '0;
            dq_sync <= '0;
            rb_meta <= 1'b1;
            rb_sync <= 1'b1;
        end else begin
            dq_meta <= flash_dq_in;
            dq_sync <= dq_meta;
            rb_meta <= ready_busy_out;
            rb_sync <= rb_meta;
        end
    end

    // Busy shown while the open-drain line is pulled low
    always_ff @(posedge clk) begin
        if (rst) begin
            dev_busy <= 1'b0;
        end else begin
            dev_busy <= ~rb_sync;
        end
    end

    // ==========================================
    // Phase timer
    phase_timer_if tmr ();
    phase_timer u_timer (
        .clk(clk),
        .rst(rst),
        .t(tmr.timer)
    );

    // Cycle count fitted to the timer width
    function automatic logic [flash_host_pkg::TMR_W-1:0] cyc(input int n);
        cyc = flash_host_pkg::TMR_W'(n);
    endfunction

    // Read-mode command for a wanted source
    function automatic logic [7:0] mode_cmd(input flash_host_pkg::src_e s);
        case (s)
            flash_host_pkg::SRC_IDENT: mode_cmd = CMD_READ_IDENT;
            flash_host_pkg::SRC_QUERY: mode_cmd = CMD_READ_QUERY;
            flash_host_pkg::SRC_STATUS: mode_cmd = CMD_READ_STATUS;
            default: mode_cmd = CMD_READ_ARRAY;
        endcase
    endfunction

    // ==========================================
    // Sequencer
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_WR_SETUP,
        ST_WR_PULSE,
        ST_WR_HOLD,
        ST_RD_ACCESS,
        ST_RECOVER,
        ST_RP_LOW,
        ST_WAKE
    } state_e;

    state_e state;                                // Current bus phase
    flash_host_pkg::src_e cur_src;                // Source the device presents
    flash_host_pkg::src_e want_src;               // Source the pending read needs
    logic read_pending;                           // A read follows the current write

    // Read source wanted by a request
    function automatic flash_host_pkg::src_e src_of(input logic [2:0] op);
        case (op)
            3'(flash_host_pkg::OP_READ_IDENT): src_of = flash_host_pkg::SRC_IDENT;
            3'(flash_host_pkg::OP_READ_QUERY): src_of = flash_host_pkg::SRC_QUERY;
            3'(flash_host_pkg::OP_READ_STATUS): src_of = flash_host_pkg::SRC_STATUS;
            default: src_of = flash_host_pkg::SRC_ARRAY;
        endcase
    endfunction

    // Bus phases, pin drive and request handling
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= ST_IDLE;
            cur_src <= flash_host_pkg::SRC_UNKNOWN;
            want_src <= flash_host_pkg::SRC_ARRAY;
            read_pending <= 1'b0;
            req_ready <= 1'b1;
            rsp_valid <= 1'b0;
            rsp_data <= '0;
            rsp_block <= '0;
            flash_addr <= '0;
            flash_dq_out <= '0;
            flash_dq_oe <= 1'b0;
            chip_select_a_n <= 1'b1;
            chip_select_b_n <= 1'b1;
            flash_oe_n <= 1'b1;
            flash_we_n <= 1'b1;
            reset_powerdown_n <= 1'b1;
            tmr.start <= 1'b0;
            tmr.load <= '0;
        end else begin
            tmr.start <= 1'b0;
            rsp_valid <= 1'b0;
            case (state)
                // Accept one request
                ST_IDLE: begin
                    if (req_valid && req_ready) begin
                        req_ready <= 1'b0;
                        flash_addr <= req_addr;
                        // Block number of the target address
                        rsp_block <= req_addr[flash_host_pkg::BLOCK_LSB +:
                                              flash_host_pkg::BLOCK_W];
                        tmr.start <= 1'b1;
                        if (req_op == 3'(flash_host_pkg::OP_DEV_RESET)) begin
                            // Pulse reset/power-down low
                            reset_powerdown_n <= 1'b0;
                            tmr.load <= cyc(flash_host_pkg::RP_LOW_CYC);
                            state <= ST_RP_LOW;
                        end else if (req_op == 3'(flash_host_pkg::OP_WRITE)) begin
                            // Raw bus write, one step of a command sequence
                            flash_dq_out <= req_wdata;
                            read_pending <= 1'b0;
                            flash_dq_oe <= 1'b1;
                            tmr.load <= cyc(flash_host_pkg::ADDR_SETUP_CYC);
                            state <= ST_WR_SETUP;
                        end else if (src_of(req_op) != cur_src) begin
                            // Switch the read source by command first
                            want_src <= src_of(req_op);
                            flash_dq_out <= {8'h00, mode_cmd(src_of(req_op))};
                            read_pending <= 1'b1;
                            flash_dq_oe <= 1'b1;
                            tmr.load <= cyc(flash_host_pkg::ADDR_SETUP_CYC);
                            state <= ST_WR_SETUP;
                        end else begin
                            // Source already right: read at once
                            chip_select_a_n <= 1'b0;
                            chip_select_b_n <= 1'b0;
                            flash_oe_n <= 1'b0;
                            tmr.load <= cyc(flash_host_pkg::READ_CYC);
                            state <= ST_RD_ACCESS;
                        end
                    end
                end
                // Address and data settle, then write-enable falls
                ST_WR_SETUP: begin
                    if (tmr.done) begin
                        chip_select_a_n <= 1'b0;
                        chip_select_b_n <= 1'b0;
                        flash_we_n <= 1'b0;
                        tmr.start <= 1'b1;
                        tmr.load <= cyc(flash_host_pkg::WE_PULSE_CYC);
                        state <= ST_WR_PULSE;
                    end
                end
                // Write-enable rises with address and data still held
                ST_WR_PULSE: begin
                    if (tmr.done) begin
                        flash_we_n <= 1'b1;
                        tmr.start <= 1'b1;
                        tmr.load <= cyc(flash_host_pkg::WR_HOLD_CYC);
                        state <= ST_WR_HOLD;
                    end
                end
                // Release the bus after hold
                ST_WR_HOLD: begin
                    if (tmr.done) begin
                        chip_select_a_n <= 1'b1;
                        chip_select_b_n <= 1'b1;
                        flash_dq_oe <= 1'b0;
                        tmr.start <= 1'b1;
                        tmr.load <= cyc(flash_host_pkg::RECOVER_CYC);
                        if (read_pending) begin
                            cur_src <= want_src;
                        end else begin
                            // Any raw write may start an alteration
                            cur_src <= flash_host_pkg::SRC_UNKNOWN;
                            rsp_valid <= 1'b1;
                        end
                        state <= ST_RECOVER;
                    end
                end
                // Selects and output-enable low, write-enable held high
                ST_RD_ACCESS: begin
                    if (tmr.done) begin
                        rsp_data <= dq_sync;
                        rsp_valid <= 1'b1;
                        chip_select_a_n <= 1'b1;
                        chip_select_b_n <= 1'b1;
                        flash_oe_n <= 1'b1;
                        tmr.start <= 1'b1;
                        tmr.load <= cyc(flash_host_pkg::RECOVER_CYC);
                        state <= ST_RECOVER;
                    end
                end
                // Idle gap; a pending read follows its mode command
                ST_RECOVER: begin
                    if (tmr.done) begin
                        if (read_pending) begin
                            read_pending <= 1'b0;
                            chip_select_a_n <= 1'b0;
                            chip_select_b_n <= 1'b0;
                            flash_oe_n <= 1'b0;
                            tmr.start <= 1'b1;
                            tmr.load <= cyc(flash_host_pkg::READ_CYC);
                            state <= ST_RD_ACCESS;
                        end else begin
                            req_ready <= 1'b1;
                            state <= ST_IDLE;
                        end
                    end
                end
                // Reset/power-down held low
                ST_RP_LOW: begin
                    if (tmr.done) begin
                        reset_powerdown_n <= 1'b1;
                        tmr.start <= 1'b1;
                        tmr.load <= cyc(WAKE_CYCLES);
                        state <= ST_WAKE;
                    end
                end
                // Device wakes in array mode
                ST_WAKE: begin
                    if (tmr.done) begin
                        cur_src <= flash_host_pkg::SRC_ARRAY;
                        rsp_valid <= 1'b1;
                        req_ready <= 1'b1;
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    req_ready <= 1'b1;
                end
            endcase
        end
    end
endmodule

/* File: tb/flash_dev_model.sv */
// Behavioural model of the parallel flash device facing the host
`timescale 1ns/10ps
module flash_dev_model #(
    parameter int BUSY_NS = 300,              // Internal alteration time
    parameter int ACCESS_NS = 60,             // Output access delay
    parameter logic [4:0] LOCK_BLK = 5'h03,   // Block held locked
    parameter logic [15:0] ID_WORD = 16'h0000 // Identifier word, value arbitrary
) (
    input wire logic [20:0] addr,
    input wire logic [15:0] dq_host,
    input wire logic dq_host_oe,
    input wire logic chip_select_a_n,
    input wire logic chip_select_b_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic reset_powerdown_n,
    input wire logic prog_ok,
    input wire logic core_ok,
    output logic [15:0] dq_bus,
    output logic ready_busy_out
);
    // ==========================================
    // Device state
    logic [1:0] mode = 2'h0; // Array, ident, query, status; array at power-up
    logic armed = 1'b0;      // Alteration set-up seen
    logic busy = 1'b0;       // Internal state machine running
    logic fail = 1'b0;       // Last alteration refused
    logic held = 1'b0;       // Alteration suspended
    logic [20:0] lat_addr;   // Latched address
    logic [15:0] lat_data;   // Latched data
    logic [15:0] word;       // Word of the current read mode
    logic [15:0] dev_out;    // Device side of the data lines
    logic sel;               // Selected and output enabled
    // ==========================================
    // Command interface, latching on the strobe rise
    always @(posedge we_n) begin
        if (!chip_select_a_n && !chip_select_b_n && reset_powerdown_n && core_ok) begin
            lat_addr = addr;
            lat_data = dq_host;
            if (armed) begin
                armed = 1'b0;
                mode = 2'h3;
                fail = !prog_ok || lat_addr[20:16] == LOCK_BLK;
                if (!fail) begin
                    busy = 1'b1;
                    busy <= #(BUSY_NS) 1'b0;
                end
            end else begin
                case (lat_data[7:0])
                    8'hff: mode = 2'h0;
                    8'h90: mode = 2'h1;
                    8'h98: mode = 2'h2;
                    8'h70: mode = 2'h3;
                    8'h40: armed = 1'b1;
                    8'hb0: begin
                        held = busy;
                        busy = 1'b0;
                    end
                    8'hd0: begin
                        busy = held;
                        held = 1'b0;
                        busy <= #(BUSY_NS) 1'b0;
                    end
                    default: ;
                endcase
            end
        end
    end
    // Power-down entry returns to array reads
    always @(negedge reset_powerdown_n) begin
        mode = 2'h0;
        armed = 1'b0;
    end
    // Read word of the selected source
    always_comb begin
        case (mode)
            2'h0: word = addr[16:1] ^ 16'h5a3c;
            2'h1: word = ID_WORD;
            2'h2: word = {8'h00, addr[7:0]};
            default: word = {8'h00, !busy, 3'h0, fail, 3'h0};
        endcase
    end
    assign sel = !chip_select_a_n && !chip_select_b_n && !oe_n && reset_powerdown_n;
    // Floating lines show the inverse so stale data never passes
    assign #(ACCESS_NS) dev_out = sel ? word : ~word;
    assign dq_bus = dq_host_oe ? dq_host : dev_out;
    assign ready_busy_out = !busy;
endmodule

/* File: tb/flash_host_ctrl_sva.sv */
// Pin protocol checker for the flash host controller
`timescale 1ns/10ps
module flash_host_ctrl_sva (
    input wire logic clk,
    input wire logic rst,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire logic dev_busy,
    input wire logic [20:0] flash_addr,
    input wire logic [15:0] flash_dq_out,
    input wire logic flash_dq_oe,
    input wire logic chip_select_a_n,
    input wire logic chip_select_b_n,
    input wire logic flash_oe_n,
    input wire logic flash_we_n,
    input wire logic reset_powerdown_n,
    input wire logic ready_busy_out
);
    // ==========================================
    // Clocking and write steps
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_we_low;
        (!flash_we_n && flash_dq_oe && !chip_select_a_n && !chip_select_b_n)[*8];
    endsequence
    sequence s_we_hold;
        (!chip_select_a_n && flash_dq_oe && $stable(flash_addr) && $stable(flash_dq_out))[*2];
    endsequence
    // ==========================================
    // Properties
    property p_read_sel; !flash_oe_n |-> !chip_select_a_n && !chip_select_b_n; endproperty
    property p_read_quiet; !flash_oe_n |-> flash_we_n && reset_powerdown_n; endproperty
    property p_no_fight; !flash_oe_n |-> !flash_dq_oe; endproperty
    property p_we_pulse; $fell(flash_we_n) |-> s_we_low; endproperty
    property p_we_hold; $rose(flash_we_n) |-> s_we_hold; endproperty
    property p_rp_width; $fell(reset_powerdown_n) |-> (!reset_powerdown_n)[*8]; endproperty
    property p_busy_seen; (!ready_busy_out)[*5] |-> dev_busy; endproperty
    property p_ready_seen; ready_busy_out[*5] |-> !dev_busy; endproperty
    property p_take; req_valid && req_ready |=> !req_ready; endproperty
    property p_rsp_pulse; rsp_valid |=> !rsp_valid; endproperty
    a_read_sel: assert property (p_read_sel) else $error("read without both selects");
    a_read_quiet: assert property (p_read_quiet) else $error("strobe active in read");
    a_no_fight: assert property (p_no_fight) else $error("host drives data in read");
    a_we_pulse: assert property (p_we_pulse) else $error("write strobe too short");
    a_we_hold: assert property (p_we_hold) else $error("write data not held");
    a_rp_width: assert property (p_rp_width) else $error("power-down pulse short");
    a_busy_seen: assert property (p_busy_seen) else $error("busy not reported");
    a_ready_seen: assert property (p_ready_seen) else $error("ready not reported");
    a_take: assert property (p_take) else $error("ready stayed after take");
    a_rsp_pulse: assert property (p_rsp_pulse) else $error("response longer than a cycle");
endmodule
bind flash_host_ctrl flash_host_ctrl_sva u_sva (.clk(clk), .rst(rst), .req_valid(req_valid),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .dev_busy(dev_busy), .flash_addr(flash_addr),
    .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe), .chip_select_a_n(chip_select_a_n),
    .chip_select_b_n(chip_select_b_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
    .reset_powerdown_n(reset_powerdown_n), .ready_busy_out(ready_busy_out));

/* File: tb/flash_bus_command_access_tb_top.sv */
// Self-checking bench for the flash host controller
`timescale 1ns/10ps
module flash_bus_command_access_tb_top;
    // ==========================================
    // Signals
    localparam logic [15:0] ID_WORD = 16'h00c5; // Value arbitrary
    localparam logic [4:0] LOCK_BLK = 5'h03;    // Locked block
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    logic [2:0] req_op = 3'h0;
    logic [20:0] req_addr = 21'h000000;
    logic [15:0] req_wdata = 16'h0000;
    logic prog_ok = 1'b1;
    logic core_ok = 1'b1;
    logic fail_exp = 1'b0;
    logic req_ready, rsp_valid, dev_busy, dq_oe, ce_a_n, ce_b_n, oe_n, we_n, rp_n, rb_out;
    logic [15:0] rsp_data, dq_out, dq_in;
    logic [4:0] rsp_block;
    logic [20:0] f_addr;
    int err_count = 0;
    int comparisons = 0;
    int seed = 83;
    flash_host_ctrl #(.WAKE_CYCLES(4)) DUT (.clk(clk), .rst(rst), .req_valid(req_valid),
        .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_block(rsp_block), .dev_busy(dev_busy),
        .flash_addr(f_addr), .flash_dq_in(dq_in), .flash_dq_out(dq_out), .flash_dq_oe(dq_oe),
        .chip_select_a_n(ce_a_n), .chip_select_b_n(ce_b_n), .flash_oe_n(oe_n),
        .flash_we_n(we_n), .reset_powerdown_n(rp_n), .ready_busy_out(rb_out));
    flash_dev_model #(.LOCK_BLK(LOCK_BLK), .ID_WORD(ID_WORD)) u_dev (.addr(f_addr),
        .dq_host(dq_out), .dq_host_oe(dq_oe), .chip_select_a_n(ce_a_n), .chip_select_b_n(ce_b_n),
        .oe_n(oe_n), .we_n(we_n), .reset_powerdown_n(rp_n), .prog_ok(prog_ok),
        .core_ok(core_ok), .dq_bus(dq_in), .ready_busy_out(rb_out));
    initial begin
        forever #2.5 clk = ~clk;
    end
    // ==========================================
    // Helpers
    function automatic logic [15:0] exp_word(input logic [2:0] op, input logic [20:0] a);
        case (op)
            3'h0: exp_word = a[16:1] ^ 16'h5a3c;
            3'h1: exp_word = ID_WORD;
            3'h2: exp_word = {8'h00, a[7:0]};
            default: exp_word = {8'h00, 4'h8, fail_exp, 3'h0};
        endcase
    endfunction
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic close_out;
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic wait_for(input logic sel_rsp, input int lim);
        int n;
        n = 0;
        while ((sel_rsp ? rsp_valid : req_ready) !== 1'b1 && n < lim) begin
            @(negedge clk);
            n++;
        end
        if (n >= lim) begin
            err_count++;
            $display("CHECK FAILED handshake wait expected 1 seen %b",
                     sel_rsp ? rsp_valid : req_ready);
            close_out();
        end
    endtask
    task automatic do_req(input logic [2:0] op, input logic [20:0] a, input logic [15:0] d,
                          output logic [15:0] q);
        @(negedge clk);
        req_op = op;
        req_addr = a;
        req_wdata = d;
        req_valid = 1'b1;
        wait_for(1'b0, 400);
        @(negedge clk);
        req_valid = 1'b0;
        wait_for(1'b1, 4000);
        q = rsp_data;
        chk("rsp_block", {11'h0, a[20:16]}, {11'h0, rsp_block});
    endtask
    task automatic rd(input logic [2:0] op, input logic [20:0] a);
        logic [15:0] q;
        do_req(op, a, 16'h0000, q);
        chk("read_word", exp_word(op, a), q);
    endtask
    task automatic alter(input logic [20:0] a, input logic pv, input logic cv);
        logic [15:0] q;
        logic seen;
        @(negedge clk);
        prog_ok = pv;
        core_ok = cv;
        do_req(3'h4, a, 16'h0040, q);
        do_req(3'h4, a, 16'h00a5, q);
        seen = 1'b0;
        repeat (200) begin
            @(negedge clk);
            seen = seen | (dev_busy === 1'b1);
        end
        prog_ok = 1'b1;
        core_ok = 1'b1;
        chk("busy_seen", {15'h0, pv && cv && a[20:16] != LOCK_BLK}, {15'h0, seen});
        if (cv) begin
            fail_exp = !pv || a[20:16] == LOCK_BLK;
        end
        rd(3'h3, a);
        rd(3'h0, a);
    endtask
    // ==========================================
    // Main sequence
    initial begin
        logic [15:0] q;
        logic [31:0] r;
        repeat (2) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        for (int i = 0; i < 4; i++) begin
            r = $random(seed);
            rd(i[2:0], r[20:0]);
        end
        $display("read mode test done");
        rd(3'h1, 21'h000000);
        do_req(3'h5, 21'h000000, 16'h0000, q);
        rd(3'h0, 21'h070000);
        $display("power-down test done");
        do_req(3'h4, 21'h050000, 16'h00a5, q);
        rd(3'h3, 21'h050000);
        $display("stray write test done");
        alter(21'h1ffffe, 1'b1, 1'b1);
        alter(21'h150000, 1'b0, 1'b1);
        alter(21'h030000, 1'b1, 1'b1);
        alter(21'h020000, 1'b1, 1'b0);
        alter(21'h02ffff, 1'b1, 1'b1);
        $display("alteration test done");
        do_req(3'h4, 21'h100000, 16'h0040, q);
        do_req(3'h4, 21'h100000, 16'h0011, q);
        chk("alter_busy", 16'h0001, {15'h0, dev_busy});
        do_req(3'h4, 21'h100000, 16'h00b0, q);
        rd(3'h0, 21'h0a0000);
        chk("suspend_busy", 16'h0000, {15'h0, dev_busy});
        do_req(3'h4, 21'h100000, 16'h00d0, q);
        repeat (100) @(negedge clk);
        $display("suspend test done");
        for (int i = 0; i < 16; i++) begin
            r = $random(seed);
            rd({1'b0, r[22:21]}, r[20:0]);
        end
        $display("random read test done");
        close_out();
    end
endmodule
